// *** verilog/ops_pkg.sv ***
package ops_pkg;
    // Clock and derived counts
    localparam int CLK_NS     = 5;          // Clock period, ns
    localparam int MS_NS      = 1000000;    // One millisecond, ns
    localparam int MS_CYC     = MS_NS / CLK_NS;
    localparam int TICK_MS    = 5;          // Measurement time base, ms
    localparam int PRE_MS     = 20;         // Pre-trigger look-back, ms
    localparam int PREF_MS    = 200;        // Pre-fault look-back, ms
    localparam int PRE_TICKS  = PRE_MS / TICK_MS;
    localparam int HIST_N     = PREF_MS / TICK_MS;
    localparam int MAX_DLY_MS = 1800000;    // Longest operate delay, ms
    localparam int MAX_DLY    = MAX_DLY_MS / TICK_MS;
    localparam int LOG_N      = 12;         // Operation records kept
    localparam int GROUPS     = 8;          // Setting groups
    // Pick-up arithmetic
    localparam logic [39:0] RST_PCT   = 40'd97;     // Reset ratio, percent
    localparam logic [39:0] PCT       = 40'd100;
    localparam logic [43:0] LL_SCALE  = 44'd591;    // 1/sqrt(3) in Q10
    localparam logic [23:0] PSET_DEF  = 24'd10000;  // 100 kW in 0.01 kW
    localparam logic [18:0] DLY_DEF   = 19'd20;     // Operate delay, 5 ms units
    localparam logic [31:0] RATIO_MAX = 32'd125000; // 1250.00 in 0.01
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_GROUP  = 8'h04;
    localparam logic [7:0] OFS_DELAY  = 8'h08;
    localparam logic [7:0] OFS_COND   = 8'h0c;
    localparam logic [7:0] OFS_RATIO  = 8'h10;
    localparam logic [7:0] OFS_EXPT   = 8'h14;
    localparam logic [7:0] OFS_REMAIN = 8'h18;
    localparam logic [7:0] OFS_POWER  = 8'h1c;
    localparam logic [7:0] OFS_CNT_ST = 8'h20;
    localparam logic [7:0] OFS_CNT_TR = 8'h24;
    localparam logic [7:0] OFS_CNT_BL = 8'h28;
    localparam logic [7:0] OFS_PSET0  = 8'h40;  // Eight words, one per group
    localparam logic [7:0] OFS_LOGSEL = 8'h60;
    localparam logic [7:0] OFS_LOG0   = 8'h64;  // Six words of the chosen record
    // Control field positions
    localparam int CB_FORCE  = 0;
    localparam int CB_FSEL   = 1;   // Two bits
    localparam int CB_MON    = 3;
    localparam int CB_MOFF   = 4;
    localparam int CB_LL     = 5;
    localparam int CB_CLR    = 6;
    localparam logic [5:0] CTRL_DEF = 6'h18;

    typedef enum logic [1:0] {C_NORMAL, C_START, C_TRIP, C_BLOCKED} ops_cond_t;

    // Fundamental RMS inputs, one per channel
    typedef struct packed {
        logic [15:0] i_a;
        logic [15:0] i_b;
        logic [15:0] i_c;
        logic [15:0] u1;
        logic [15:0] u2;
        logic [15:0] u3;
        logic [15:0] u4;
    } ops_meas_t;

    // Event strobes with their time stamp
    typedef struct packed {
        logic [2:0]  on;     // Start, trip, block rising
        logic [2:0]  off;    // Start, trip, block falling
        logic [31:0] stamp;  // Milliseconds
    } ops_evt_t;

    // One operation record
    typedef struct packed {
        logic [31:0] stamp;
        logic [1:0]  kind;
        logic [3:0]  group;
        logic [31:0] pre_p;
        logic [31:0] flt_p;
        logic [31:0] pref_p;
        logic [18:0] remain;
    } ops_log_t;
endpackage

// *** verilog/ops_stage.sv ***
// Notes on behaviour
// R1: Take three currents, four voltages, 5 ms refresh
// R2: Power from currents and LN or LL voltages
// R3: Pick up when power exceeds setting
// R4: Setting in 0.01 kW steps, default 100 kW
// R5: Release below 97 percent of setting
// R6: Report power to setting ratio, 0.01 resolution
// R7: Active setting group selects setting live
// R8: Force status overrides only when forcing enabled
// R9: Read condition Normal, Start, Trip or Blocked
// R10: Sample block input each program cycle start
// R11: Unblocked pick-up asserts start, begins timing
// R12: Blocked pick-up asserts blocked, no timing
// R13: Late block drops start like a release
// R14: Blocking source must lead trip by 5 ms
// R15: Definite time delay only
// R16: Report expected and remaining time, 5 ms
// R17: Six on/off events, masked by user
// R18: Every event carries a time stamp
// R19: Resettable counters for start, trip, blocked
// R20: Exactly one stage
// R21: Circular log of twelve records
// R22: Log on rising events with powers, group
// R23: Timer clears whenever start drops
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module ops_stage #(  // A single stage by design [R20]
    parameter int MS_CYC = ops_pkg::MS_CYC  // Cycles per millisecond
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire ops_pkg::ops_meas_t meas,
    input  wire logic              meas_valid,
    input  wire logic              block_in,
    output logic                   start_o,
    output logic                   trip_o,
    output logic                   blocked_o,
    output ops_pkg::ops_evt_t      evt_o
);
    // Software state
    logic [5:0]  ctrl_r;                           // Control bits
    logic [2:0]  grp_r;                            // Active group, 0 based
    logic [18:0] dly_r;                            // Operate delay, 5 ms units
    logic [23:0] pset_r [ops_pkg::GROUPS];         // Pick-up per group
    logic [3:0]  lsel_r;                           // Record chosen for read
    // Measurement and decision state
    logic [31:0] pwr_r;                            // Power, 0.01 kW
    logic        tick_r;                           // Program cycle strobe
    logic        blk_r;                            // Block sampled per cycle
    logic        pu_r;                             // Pick-up with hysteresis
    ops_pkg::ops_cond_t st_r;                      // Unforced condition
    logic [18:0] tmr_r;                            // Elapsed delay, 5 ms units
    logic [31:0] ratio_r;                          // Power over setting
    logic [31:0] ms_r;                             // Millisecond stamp
    logic [17:0] div_r;                            // Millisecond divider
    logic [15:0] cnt_r [3];                        // Start, trip, block counts
    logic [31:0] hist_r [ops_pkg::HIST_N];         // Past power, 5 ms apart
    logic [5:0]  hp_r;                             // Next history slot
    ops_pkg::ops_log_t log_r [ops_pkg::LOG_N];     // Record ring
    logic [3:0]  lp_r;                             // Next record slot
    // Divider
    logic [39:0] dv_num_r;
    logic [23:0] dv_den_r;
    logic [24:0] dv_rem_r;
    logic [5:0]  dv_cnt_r;

    // Bus decode
    logic        acc;                              // Access phase completes
    logic        wr;
    logic        clr_cnt;
    logic        force_en;
    ops_pkg::ops_cond_t force_sel;
    ops_pkg::ops_cond_t eff;                       // Condition after forcing
    logic [2:0]  flg;                              // Start, trip, block levels
    logic [2:0]  rise;
    logic [2:0]  fall;
    logic [23:0] pset;
    logic [31:0] pwr_calc;
    logic        above;
    logic        below;
    logic        pu_nxt;
    logic [18:0] remain;
    logic [5:0]  pre_idx;

    assign acc       = psel & penable & pready;
    assign wr        = acc & pwrite;
    assign clr_cnt   = wr && paddr == ops_pkg::OFS_CTRL && pwdata[ops_pkg::CB_CLR];
    assign force_en  = ctrl_r[ops_pkg::CB_FORCE];
    assign force_sel = ops_pkg::ops_cond_t'(ctrl_r[ops_pkg::CB_FSEL +: 2]);
    assign pset      = pset_r[grp_r];              // [R7]

    // One channel's product, widened so nothing is lost
    function automatic logic [33:0] prod(logic [15:0] a, logic [15:0] b);
        prod = {18'h0, a} * {18'h0, b};
    endfunction

    // Three-phase power; the fourth voltage feeds no product here
    always_comb begin
        logic [33:0] p_sum;
        logic [43:0] p_ll;
        p_sum = prod(meas.i_a, meas.u1) + prod(meas.i_b, meas.u2)
              + prod(meas.i_c, meas.u3);                       // [R2]
        p_ll  = {10'h0, p_sum} * ops_pkg::LL_SCALE;
        if (ctrl_r[ops_pkg::CB_LL]) begin
            // Line-to-line voltages carry a sqrt(3) too many
            pwr_calc = (|p_ll[43:42]) ? 32'hffff_ffff : p_ll[41:10];
        end else begin
            pwr_calc = (|p_sum[33:32]) ? 32'hffff_ffff : p_sum[31:0];
        end
    end

    // Pick-up comparator with fixed reset ratio
    assign above  = pwr_r > {8'h00, pset};                                // [R3]
    assign below  = {8'h00, pwr_r} * ops_pkg::PCT
                  < {16'h0000, pset} * ops_pkg::RST_PCT;                  // [R5]
    assign pu_nxt = pu_r ? !below : above;
    assign remain = (st_r == ops_pkg::C_START) ? dly_r - tmr_r : 19'h0;  // [R16]
    assign pre_idx = (hp_r > 6'(ops_pkg::PRE_TICKS)) ? hp_r - 6'(ops_pkg::PRE_TICKS + 1)
                   : hp_r + 6'(ops_pkg::HIST_N - ops_pkg::PRE_TICKS - 1);

    // Effective condition and its edges
    assign eff  = force_en ? force_sel : st_r;                            // [R8]
    assign flg  = {eff == ops_pkg::C_BLOCKED, eff == ops_pkg::C_TRIP,
                   eff == ops_pkg::C_START};
    assign rise = flg & ~{blocked_o, trip_o, start_o};
    assign fall = ~flg & {blocked_o, trip_o, start_o};

    // APB: one wait state, answer in second access cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (psel & penable & ~pready) begin
                unique casez (paddr)
                    ops_pkg::OFS_CTRL:   prdata <= {26'h0, ctrl_r};
                    ops_pkg::OFS_GROUP:  prdata <= {29'h0, grp_r};
                    ops_pkg::OFS_DELAY:  prdata <= {13'h0, dly_r};
                    ops_pkg::OFS_COND:   prdata <= {30'h0, eff};        // [R9]
                    ops_pkg::OFS_RATIO:  prdata <= ratio_r;             // [R6]
                    ops_pkg::OFS_EXPT:   prdata <= {13'h0, dly_r};      // [R16]
                    ops_pkg::OFS_REMAIN: prdata <= {13'h0, remain};     // [R16]
                    ops_pkg::OFS_POWER:  prdata <= pwr_r;
                    ops_pkg::OFS_CNT_ST: prdata <= {16'h0, cnt_r[0]};   // [R19]
                    ops_pkg::OFS_CNT_TR: prdata <= {16'h0, cnt_r[1]};
                    ops_pkg::OFS_CNT_BL: prdata <= {16'h0, cnt_r[2]};
                    8'b010?_??00:        prdata <= {8'h0, pset_r[paddr[4:2]]};
                    ops_pkg::OFS_LOGSEL: prdata <= {28'h0, lsel_r};
                    8'h64, 8'h68, 8'h6c, 8'h70, 8'h74, 8'h78: begin
                        // Chosen record, word by word
                        unique case (paddr)
                            8'h64:   prdata <= log_r[lsel_r].stamp;
                            8'h68:   prdata <= {26'h0, log_r[lsel_r].group,
                                                log_r[lsel_r].kind};
                            8'h6c:   prdata <= log_r[lsel_r].pre_p;
                            8'h70:   prdata <= log_r[lsel_r].flt_p;
                            8'h74:   prdata <= log_r[lsel_r].pref_p;
                            default: prdata <= {13'h0, log_r[lsel_r].remain};
                        endcase
                    end
                    default:             pslverr <= 1'b1;   // Unmapped
                endcase
            end
        end
    end

    // Software-written settings
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_r <= ops_pkg::CTRL_DEF;
            grp_r  <= 3'h0;
            dly_r  <= ops_pkg::DLY_DEF;
            lsel_r <= 4'h0;
            for (int g = 0; g < ops_pkg::GROUPS; g++) begin
                pset_r[g] <= ops_pkg::PSET_DEF;                 // [R4]
            end
        end else if (wr) begin
            if (paddr == ops_pkg::OFS_CTRL) begin
                ctrl_r <= pwdata[5:0];  // Clear bit is a strobe, not kept
            end
            if (paddr == ops_pkg::OFS_GROUP) begin
                grp_r <= pwdata[2:0];                           // [R7]
            end
            if (paddr == ops_pkg::OFS_DELAY) begin
                // Longer than the span is clamped, not wrapped
                dly_r <= (pwdata > ops_pkg::MAX_DLY) ? 19'(ops_pkg::MAX_DLY)
                       : pwdata[18:0];                          // [R15]
            end
            if (paddr[7:5] == 3'b010 && paddr[1:0] == 2'b00) begin
                pset_r[paddr[4:2]] <= pwdata[23:0];             // [R4]
            end
            if (paddr == ops_pkg::OFS_LOGSEL && pwdata[3:0] < 4'(ops_pkg::LOG_N)) begin
                lsel_r <= pwdata[3:0];
            end
        end
    end

    // Millisecond stamp from a divider enable
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div_r <= 18'h0;
            ms_r  <= 32'h0;
        end else if (div_r == 18'(MS_CYC - 1)) begin
            div_r <= 18'h0;
            ms_r  <= ms_r + 32'h1;                              // [R18]
        end else begin
            div_r <= div_r + 18'h1;
        end
    end

    // Power latched on each 5 ms update; decisions run one cycle later
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pwr_r  <= 32'h0;
            tick_r <= 1'b0;
            blk_r  <= 1'b0;
        end else begin
            tick_r <= meas_valid;                               // [R1]
            if (meas_valid) begin
                pwr_r <= pwr_calc;                              // [R1]
                blk_r <= block_in;                              // [R10]
            end
        end
    end

    // Power history ring for the look-back values
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hp_r <= 6'h0;
            for (int h = 0; h < ops_pkg::HIST_N; h++) begin
                hist_r[h] <= 32'h0;
            end
        end else if (tick_r) begin
            hist_r[hp_r] <= pwr_r;
            hp_r <= (hp_r == 6'(ops_pkg::HIST_N - 1)) ? 6'h0 : hp_r + 6'h1;
        end
    end

    // Stage decision, once per program cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pu_r <= 1'b0;
            st_r <= ops_pkg::C_NORMAL;
        end else if (tick_r) begin
            pu_r <= pu_nxt;
            unique case (st_r)
                ops_pkg::C_NORMAL, ops_pkg::C_BLOCKED: begin
                    if (!pu_nxt) begin
                        st_r <= ops_pkg::C_NORMAL;
                    end else begin
                        st_r <= blk_r ? ops_pkg::C_BLOCKED      // [R12]
                                      : ops_pkg::C_START;       // [R11]
                    end
                end
                ops_pkg::C_START: begin
                    if (!pu_nxt) begin
                        st_r <= ops_pkg::C_NORMAL;
                    end else if (blk_r) begin
                        st_r <= ops_pkg::C_BLOCKED;             // [R13]
                    end else if (tmr_r + 19'h1 >= dly_r) begin
                        st_r <= ops_pkg::C_TRIP;                // [R15]
                    end
                end
                ops_pkg::C_TRIP: begin
                    // Held until the power drops or a block arrives
                    if (!pu_nxt) begin
                        st_r <= ops_pkg::C_NORMAL;
                    end else if (blk_r) begin
                        st_r <= ops_pkg::C_BLOCKED;
                    end
                end
            endcase
        end
    end

    // Definite-time counter, zero outside the start state
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tmr_r <= 19'h0;
        end else if (st_r != ops_pkg::C_START) begin
            tmr_r <= 19'h0;                                     // [R23]
        end else if (tick_r && tmr_r < dly_r) begin
            tmr_r <= tmr_r + 19'h1;                             // [R15]
        end
    end

    // Serial ratio divider, restarted each program cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dv_num_r <= 40'h0;
            dv_den_r <= 24'h0;
            dv_rem_r <= 25'h0;
            dv_cnt_r <= 6'h0;
            ratio_r  <= 32'h0;
        end else if (tick_r) begin
            dv_num_r <= {8'h00, pwr_r} * ops_pkg::PCT;          // [R6]
            dv_den_r <= pset;
            dv_rem_r <= 25'h0;
            dv_cnt_r <= 6'd40;
        end else if (dv_cnt_r != 6'h0) begin
            logic [24:0] r;
            r = {dv_rem_r[23:0], dv_num_r[39]};
            dv_cnt_r <= dv_cnt_r - 6'h1;
            if (r >= {1'b0, dv_den_r}) begin
                dv_rem_r <= r - {1'b0, dv_den_r};
                dv_num_r <= {dv_num_r[38:0], 1'b1};
            end else begin
                dv_rem_r <= r;
                dv_num_r <= {dv_num_r[38:0], 1'b0};
            end
            if (dv_cnt_r == 6'h1) begin
                // Saturate at the display span; a zero setting reads full
                if (dv_den_r == 24'h0 || dv_num_r[38:31] != 8'h0 ||
                    {dv_num_r[30:0], 1'b0} > ops_pkg::RATIO_MAX) begin
                    ratio_r <= ops_pkg::RATIO_MAX;
                end else begin
                    ratio_r <= {dv_num_r[30:0], r >= {1'b0, dv_den_r}};
                end
            end
        end
    end

    // Registered outputs and masked events
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            start_o   <= 1'b0;
            trip_o    <= 1'b0;
            blocked_o <= 1'b0;
            evt_o     <= '0;
        end else begin
            {blocked_o, trip_o, start_o} <= flg;                // [R9]
            evt_o.on    <= rise & {3{ctrl_r[ops_pkg::CB_MON]}};   // [R17]
            evt_o.off   <= fall & {3{ctrl_r[ops_pkg::CB_MOFF]}};  // [R17]
            evt_o.stamp <= ms_r;                                // [R18]
        end
    end

    // Counters; a count in the clearing cycle survives as one
    for (genvar k = 0; k < 3; k++) begin : g_cnt
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                cnt_r[k] <= 16'h0;
            end else if (clr_cnt) begin
                cnt_r[k] <= {15'h0, rise[k]};                   // [R19]
            end else if (rise[k]) begin
                cnt_r[k] <= cnt_r[k] + 16'h1;                   // [R19]
            end
        end
    end

    // Record ring, written on rising events only; trip first
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lp_r <= 4'h0;
            for (int e = 0; e < ops_pkg::LOG_N; e++) begin
                log_r[e] <= '0;
            end
        end else if (|rise) begin
            log_r[lp_r].stamp  <= ms_r;                         // [R22]
            log_r[lp_r].kind   <= rise[1] ? 2'd1 : rise[0] ? 2'd0 : 2'd2;
            log_r[lp_r].group  <= {1'b0, grp_r} + 4'h1;         // [R22]
            log_r[lp_r].pre_p  <= hist_r[pre_idx];              // [R22]
            log_r[lp_r].flt_p  <= pwr_r;
            log_r[lp_r].pref_p <= hist_r[hp_r];                 // [R22]
            log_r[lp_r].remain <= remain;
            lp_r <= (lp_r == 4'(ops_pkg::LOG_N - 1)) ? 4'h0 : lp_r + 4'h1; // [R21]
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_free_pick;
        tick_r && !blk_r && pu_nxt && st_r == ops_pkg::C_NORMAL;
    endsequence
    sequence s_block_pick;
        tick_r && blk_r && pu_nxt;
    endsequence

    chk_pick_start: assert property (s_free_pick |=> st_r == ops_pkg::C_START) // [R11]
        else $error("free pick-up did not start");
    chk_pick_blocked: assert property (s_block_pick |=> st_r == ops_pkg::C_BLOCKED) // [R12]
        else $error("blocked pick-up not blocked");
    chk_block_drop: assert property (s_block_pick ##0 st_r == ops_pkg::C_START // [R13]
        |=> ##1 tmr_r == 19'h0 && (!start_o || force_en))
        else $error("block did not drop start");
    chk_pickup_up: assert property (tick_r && above |=> pu_r) // [R3]
        else $error("pick-up missed");
    chk_hold_ratio: assert property (tick_r && pu_r && !below |=> pu_r) // [R5]
        else $error("released above reset ratio");
    chk_force_cond: assert property (force_en |=> // [R8]
        {blocked_o, trip_o, start_o} == $past({force_sel == ops_pkg::C_BLOCKED,
        force_sel == ops_pkg::C_TRIP, force_sel == ops_pkg::C_START}))
        else $error("forced status not shown");
    chk_timer_clear: assert property (st_r != ops_pkg::C_START |=> tmr_r == 19'h0) // [R23]
        else $error("timer kept value");
    chk_count_start: assert property (rise[0] && !clr_cnt |=> // [R19]
        cnt_r[0] == $past(cnt_r[0]) + 16'h1)
        else $error("start count not advanced");
    chk_log_wrap: assert property (|rise && lp_r == 4'(ops_pkg::LOG_N - 1) |=> // [R21]
        lp_r == 4'h0)
        else $error("record ring did not wrap");
    chk_trip_delay: assert property (tick_r && st_r == ops_pkg::C_START && // [R15]
        pu_nxt && !blk_r && tmr_r + 19'h1 < dly_r |=> st_r == ops_pkg::C_START)
        else $error("tripped before delay");
endmodule // ops_stage

// *** testbench/ops_meas_src.sv ***
`timescale 1ns/1ps
// Measurement subsystem and blocking matrix stand-in
module ops_meas_src #(
    parameter int PER = 50  // Program cycle in clocks, above ratio latency
) (
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    input  wire logic [15:0]   cur_a,
    input  wire logic          blk,
    output ops_pkg::ops_meas_t meas,
    output logic               meas_valid,
    output logic               block_in
);
    int cnt;  // Position in the program cycle
    // One refresh pulse per program cycle
    always_ff @(posedge ref_clk) begin
        cnt <= (sys_rst || cnt == PER - 1) ? 0 : cnt + 1;
        meas_valid <= !sys_rst && cnt == PER - 1;
    end
    // Only phase A and channel one carry load, so power is cur_a times 100
    always_comb begin
        meas = '0;
        meas.i_a = cur_a;
        meas.u1 = 16'h0064;
    end
    // Block level from the matrix; the bench sets it together with the load, before the refresh samples it
    assign block_in = blk;
endmodule // ops_meas_src

// *** testbench/ops_stage_tb.sv ***
`timescale 1ns/1ps
module ops_stage_tb;
    logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, blk = 0, er;
    logic [7:0] paddr = 8'h00;
    logic [15:0] cur_a = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, meas_valid, block_in, start_o, trip_o, blocked_o;
    ops_pkg::ops_meas_t meas;
    ops_pkg::ops_evt_t evt_o;
    int miscompares = 0, checked = 0, p, pu, ons = 0, offs = 0;
    integer seed = 32'hbec6;
    always #2.5 ref_clk = ~ref_clk;
    ops_stage #(.MS_CYC(4)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas(meas), .meas_valid(meas_valid),
        .block_in(block_in), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
        .evt_o(evt_o));
    ops_meas_src src_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .cur_a(cur_a), .blk(blk),
        .meas(meas), .meas_valid(meas_valid), .block_in(block_in));
    // Start-on pulses last one cycle, so count them as they pass
    always @(posedge ref_clk) if (evt_o.on[0] === 1'b1) ons++;
    always @(posedge ref_clk) if (evt_o.off[1] === 1'b1) offs++;
    task print_verdict;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s exp %0h got %0h", nm, e, g);
            miscompares++;
        end
    endtask
    // APB transfer, held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge ref_clk);
    endtask
    // Load and block for the next program cycle, then three edges past the outputs
    // so the event counters have settled before anything reads them
    task tick(input int pw, input logic b);
        cur_a <= 16'(pw / 100); blk <= b;
        do @(posedge ref_clk); while (meas_valid !== 1'b1);
        repeat (5) @(posedge ref_clk);
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 0;
        @(posedge ref_clk);
        apb(0, ops_pkg::OFS_PSET0, 0); chk("pickup", 10000, rd);
        apb(0, ops_pkg::OFS_COND, 0); chk("cond", 0, rd);
        apb(0, 8'hfc, 0); chk("slverr", 1, er);
        apb(1, ops_pkg::OFS_DELAY, 3);
        tick(10100, 0); chk("start", 1, start_o);
        chk("start event", 1, ons);
        apb(0, ops_pkg::OFS_REMAIN, 0);
        chk("remain", 3, rd);
        repeat (2) tick(10100, 0);
        chk("early trip", 0, trip_o);
        tick(10100, 0); chk("trip", 1, trip_o);
        apb(0, ops_pkg::OFS_CNT_TR, 0); chk("trips", 1, rd);
        repeat (40) @(posedge ref_clk);
        apb(0, ops_pkg::OFS_RATIO, 0);
        chk("ratio", 101, rd);
        tick(9750, 0); chk("hold", 1, trip_o);
        tick(9600, 0); chk("release", 0, trip_o | start_o);
        chk("trip off event", 1, offs);
        tick(10100, 0); tick(10100, 1); chk("late block", 1, blocked_o & !start_o);
        tick(0, 0); tick(10100, 1); chk("blocked", 1, blocked_o & !start_o);
        apb(1, ops_pkg::OFS_GROUP, 1); apb(1, 8'h44, 5000);
        tick(0, 0); tick(6000, 0); chk("group", 1, start_o);
        apb(1, ops_pkg::OFS_GROUP, 0); tick(6000, 0); chk("group back", 0, start_o);
        apb(1, ops_pkg::OFS_CTRL, 32'h1d); repeat (3) @(posedge ref_clk);
        chk("forced", 1, trip_o);
        apb(1, ops_pkg::OFS_CTRL, 32'h1c); repeat (3) @(posedge ref_clk);
        chk("unforced", 0, trip_o);
        apb(1, ops_pkg::OFS_CTRL, 32'h38);
        tick(10100, 0);
        apb(0, ops_pkg::OFS_POWER, 0);
        chk("ll power", 10100 * ops_pkg::LL_SCALE / 1024, rd);
        apb(1, ops_pkg::OFS_CTRL, 32'h58); apb(0, ops_pkg::OFS_CNT_ST, 0);
        chk("cleared", 0, rd);
        // Random load around the release band against an integer model
        apb(1, ops_pkg::OFS_DELAY, 360000); pu = 0;
        repeat (30) begin
            p = (95 + $unsigned($random(seed)) % 10) * 100;
            pu = (p > 10000) ? 1 : ((p * 100 < 970000) ? 0 : pu);
            tick(p, 0); chk("model start", pu, start_o);
        end
        print_verdict();
    end
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
endmodule // ops_stage_tb
